//--- shared/seq_pkg.sv
// Constants, register map and states of the power rail sequencer
package seq_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int STEP0_US = 30;
  localparam int STEP1_US = 120;
  localparam int STEP2_US = 250;
  localparam int STEP3_US = 500;
  localparam int SHUTDOWN_US = 500;
  localparam int OFF_HOLD_US = 2000;
  localparam logic [5:0] STEP0_TICKS = 6'(STEP0_US / TICK_US);
  localparam logic [5:0] STEP1_TICKS = 6'(STEP1_US / TICK_US);
  localparam logic [5:0] STEP2_TICKS = 6'(STEP2_US / TICK_US);
  localparam logic [5:0] STEP3_TICKS = 6'(STEP3_US / TICK_US);
  localparam logic [5:0] SHUTDOWN_TICKS = 6'(SHUTDOWN_US / TICK_US);
  localparam logic [7:0] OFF_HOLD_TICKS = 8'(OFF_HOLD_US / TICK_US);
  // Sequenced outputs: regulators, general output, host reset
  localparam int NUM_REG = 8;
  localparam int NUM_OUT = 10;
  localparam int GO_IDX = 8;
  localparam int RST_IDX = 9;
  // Register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] STBY_KEEP_OFS = 8'h0C;
  localparam logic [7:0] FAULT_OFS = 8'h10;
  localparam logic [7:0] SLOT_BASE = 8'h20;
  localparam logic [7:0] SLOT_END = 8'h48;
  // Field positions
  localparam int CTRL_MODE_BIT = 2;
  localparam int CTRL_OFF_BIT = 3;
  localparam int CTRL_STBY_BIT = 4;
  localparam int FLAG_PWRUP = 0;
  localparam int FLAG_SDWN = 1;
  localparam int FLAG_STBY = 2;
  // Reset values and response codes
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [7:0] STBY_KEEP_RST = 8'h00;
  localparam logic [3:0] FLT_LIM_RST = 4'hF;
  localparam logic [3:0] WD_LIM_RST = 4'hF;
  localparam logic MODE_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_UP,
    ST_RUN,
    ST_STBY_DN,
    ST_STBY,
    ST_STBY_UP,
    ST_DOWN,
    ST_FAILSAFE
  } seq_state_e;
endpackage

//--- logic/power_rail_sequencer.sv
// Slot based power up and power down sequencer with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
// How it works
// - two-bit selector picks 30/120/250/500 us step
// - step selector rewritable while on, applies to current step
// - slot code zero keeps regulator or general output off
// - code n starts output at slot n-1
// - unslotted host reset released after last slot
// - all codes zero: enter run, only host reset released
// - power-up-done flag after last slot ends
// - standby to run sequences only re-enabled regulators
// - power-up-done flag at every standby exit
// - on-pin low or held-low fall starts power down
// - software off starts 500 us timer, flag
// - clearing pending flag cancels; expiry powers down
// - expired fault timer is hard-fault turn-off
// - repeat fault count equal limit: hard-fault off
// - watchdog fail count at limit: hard-fault off
// - hard fault passes through fail-safe after down
// - order bit: 0 sequential, 1 grouped down
// - run to standby sequences only if regulators off
// - standby-entry flag at end of standby entry
// - zero codes off at once, rest reversed
// - general output dropped at its slot position
// - off mode reloads period and codes from fuses
// - level mode: pin high in off powers up
module power_rail_sequencer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [seq_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [seq_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Fused defaults
  input wire logic [1:0] fused_step_period_default,
  input wire logic [seq_pkg::NUM_OUT*8-1:0] fused_slot_codes,
  input wire logic on_pin_edge_mode,
  // Event inputs
  input wire logic power_on_request_pin,
  input wire logic reg_fault_pin,
  input wire logic fault_timer_expired,
  input wire logic watchdog_fail_event,
  // Outputs
  output logic [seq_pkg::NUM_REG-1:0] reg_enable,
  output logic power_good_pin,
  output logic host_reset_out_n,
  output logic irq_out_n,
  output logic fail_safe
);
  import seq_pkg::*;

  seq_state_e state_q;
  logic [1:0] pin_meta_q, pin_sync_q, pin_prev_q;
  logic [9:0] tick_cnt_q;
  logic tick, bound, act, first_q, hard_q, fail_safe_q, ev_up_q, ev_stby_q;
  logic [5:0] step_ticks, step_cnt_q, sd_cnt_q;
  logic [8:0] slot_q;
  logic [NUM_OUT-1:0] mask_q, out_on_q, hit, zero, stby_mask;
  logic [7:0] code [NUM_OUT];
  logic [7:0] last_mask, hold_cnt_q, keep_q, waddr_q;
  logic [1:0] tsel_q;
  logic mode_q, stby_req_q, sw_off_q, armed_q, hold_evt;
  logic [2:0] flags_q, imask_q;
  logic [3:0] flt_cnt_q, wd_cnt_q, flt_lim_q, wd_lim_q;
  logic on_state, busy, hard_evt, off_evt, pin_on, sd_expire, slave, sw_set, pend_clr;
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q, wr_en, wr_lo;
  logic [31:0] wdata_q, rdata_q, rd_val;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == CTRL_OFS || a == STATUS_OFS || a == IRQ_MASK_OFS || a == STBY_KEEP_OFS || a == FAULT_OFS ||
      (a >= SLOT_BASE && a < SLOT_END && a[1:0] == 2'h0);
  endfunction

  // Pin synchronisers; prev stage feeds edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      pin_prev_q <= 2'h0;
    end else begin
      pin_meta_q <= {reg_fault_pin, power_on_request_pin};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign tick = (tick_cnt_q == 10'(TICK_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end

  always_comb begin
    case (tsel_q)
      2'h0: step_ticks = STEP0_TICKS;
      2'h1: step_ticks = STEP1_TICKS;
      2'h2: step_ticks = STEP2_TICKS;
      default: step_ticks = STEP3_TICKS;
    endcase
  end

  // a shortened period ends the current step early
  assign bound = tick && (step_cnt_q >= step_ticks - 6'h01);
  assign act = first_q || bound;
  always_ff @(posedge aclk) begin
    if (!aresetn || first_q || bound) begin
      step_cnt_q <= 6'h00;
    end else if (tick) begin
      step_cnt_q <= step_cnt_q + 6'h01;
    end
  end

  // Slot code storage and slot match per output
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic [7:0] c_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        c_q <= 8'h00;
      end else if (state_q == ST_OFF) begin
        c_q <= fused_slot_codes[i*8 +: 8];
      end else if (wr_lo && !busy && waddr_q == SLOT_BASE + 8'(4 * i)) begin
        c_q <= wdata_q[7:0];
      end
    end
    assign code[i] = c_q;
    assign zero[i] = (c_q == 8'h00);
    // zero never matches; code n at slot n-1
    assign hit[i] = !zero[i] && !slot_q[8] && (c_q - 8'h01 == slot_q[7:0]);
  end

  always_comb begin
    last_mask = 8'h00;
    for (int k = 0; k < NUM_OUT; k++) begin
      if (mask_q[k] && !zero[k] && (code[k] - 8'h01) > last_mask) begin
        last_mask = code[k] - 8'h01;
      end
    end
  end

  // edge mode needs a fall held low
  assign hold_evt = armed_q && tick && (hold_cnt_q == OFF_HOLD_TICKS);
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_sync_q[0]) begin
      armed_q <= 1'b0;
      hold_cnt_q <= 8'h00;
    end else if (pin_prev_q[0]) begin
      armed_q <= 1'b1;
      hold_cnt_q <= 8'h00;
    end else if (armed_q && tick) begin
      armed_q <= !hold_evt;
      hold_cnt_q <= hold_cnt_q + 8'h01;
    end
  end

  // count fault reappearances; count watchdog fails
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == ST_OFF) begin
      flt_cnt_q <= 4'h0;
      wd_cnt_q <= 4'h0;
    end else begin
      if (pin_sync_q[1] && !pin_prev_q[1] && flt_cnt_q != 4'hF) begin
        flt_cnt_q <= flt_cnt_q + 4'h1;
      end
      if (watchdog_fail_event && wd_cnt_q != 4'hF) begin
        wd_cnt_q <= wd_cnt_q + 4'h1;
      end
    end
  end

  // software off request and shutdown timer
  assign sw_set = wr_lo && waddr_q == CTRL_OFS && wdata_q[CTRL_OFF_BIT] && on_state && !sw_off_q;
  assign pend_clr = wr_lo && waddr_q == STATUS_OFS && wdata_q[FLAG_SDWN];
  assign sd_expire = sw_off_q && (sd_cnt_q == SHUTDOWN_TICKS);
  always_ff @(posedge aclk) begin
    if (!aresetn || !on_state) begin
      sw_off_q <= 1'b0;
      sd_cnt_q <= 6'h00;
    end else if (sw_set) begin
      sw_off_q <= 1'b1;
      sd_cnt_q <= 6'h00;
    // clearing the pending flag cancels and self-clears
    end else if (sw_off_q && pend_clr) begin
      sw_off_q <= 1'b0;
      sd_cnt_q <= 6'h00;
    end else if (sw_off_q && tick && !sd_expire) begin
      sd_cnt_q <= sd_cnt_q + 6'h01;
    end
  end

  assign on_state = state_q inside {ST_UP, ST_RUN, ST_STBY_DN, ST_STBY, ST_STBY_UP};
  assign busy = state_q inside {ST_UP, ST_STBY_DN, ST_STBY_UP, ST_DOWN};
  assign hard_evt = fault_timer_expired || (flt_lim_q != 4'h0 && flt_cnt_q == flt_lim_q) ||
    (wd_lim_q != 4'h0 && wd_cnt_q == wd_lim_q);
  assign off_evt = sd_expire || (on_pin_edge_mode ? hold_evt : !pin_sync_q[0]);
  // level mode powers up on a high pin
  assign pin_on = on_pin_edge_mode ? hold_evt : pin_sync_q[0];
  // fused codes, stored copy still stale in off
  assign slave = (fused_slot_codes == '0);
  assign stby_mask = {2'b00, ~keep_q};

  // Power state sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_OFF;
      slot_q <= 9'h000;
      mask_q <= '0;
      out_on_q <= '0;
      first_q <= 1'b0;
      hard_q <= 1'b0;
      fail_safe_q <= 1'b0;
      ev_up_q <= 1'b0;
      ev_stby_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      fail_safe_q <= 1'b0;
      ev_up_q <= 1'b0;
      ev_stby_q <= 1'b0;
      if (on_state && (hard_evt || off_evt)) begin
        state_q <= ST_DOWN;
        hard_q <= hard_evt;
        mask_q <= '1;
        first_q <= 1'b1;
      end else begin
        case (state_q)
          ST_OFF: begin
            if (pin_on) begin
              mask_q <= '1;
              slot_q <= 9'h000;
              // slave mode goes straight to run
              if (slave) begin
                state_q <= ST_RUN;
                out_on_q[RST_IDX] <= 1'b1;
                ev_up_q <= 1'b1;
              end else begin
                state_q <= ST_UP;
                first_q <= 1'b1;
              end
            end
          end
          ST_UP, ST_STBY_UP: begin
            // finish one step after the last slot
            if (bound && slot_q > {1'b0, last_mask}) begin
              state_q <= ST_RUN;
              ev_up_q <= 1'b1;
              if (zero[RST_IDX]) begin
                out_on_q[RST_IDX] <= 1'b1;
              end
            // enables change on slot boundaries only
            end else if (act) begin
              out_on_q <= out_on_q | (hit & mask_q);
              slot_q <= slot_q + 9'h001;
            end
          end
          ST_RUN: begin
            if (stby_req_q) begin
              mask_q <= stby_mask;
              // sequence only when a regulator turns off
              if (|(out_on_q & stby_mask)) begin
                state_q <= ST_STBY_DN;
                first_q <= 1'b1;
              end else begin
                state_q <= ST_STBY;
                ev_stby_q <= 1'b1;
              end
            end
          end
          ST_STBY: begin
            if (!stby_req_q) begin
              mask_q <= stby_mask;
              slot_q <= 9'h000;
              // sequence only when a regulator turns on
              if (|(stby_mask & ~zero & ~out_on_q)) begin
                state_q <= ST_STBY_UP;
                first_q <= 1'b1;
              end else begin
                state_q <= ST_RUN;
                ev_up_q <= 1'b1;
              end
            end
          end
          ST_DOWN, ST_STBY_DN: begin
            if (first_q) begin
              if (mode_q) begin
                out_on_q <= out_on_q & ~mask_q;
                slot_q <= 9'h1FF;
              end else begin
                out_on_q <= out_on_q & ~(mask_q & zero);
                slot_q <= {1'b0, last_mask};
              end
            end else if (bound) begin
              if (slot_q[8]) begin
                state_q <= (state_q == ST_STBY_DN) ? ST_STBY : (hard_q ? ST_FAILSAFE : ST_OFF);
                ev_stby_q <= (state_q == ST_STBY_DN);
              // reverse slot order, general output included except in standby entry
              end else begin
                out_on_q <= out_on_q & ~(hit & mask_q);
                slot_q <= slot_q - 9'h001;
              end
            end
          end
          ST_FAILSAFE: begin
            fail_safe_q <= 1'b1;
            hard_q <= 1'b0;
            state_q <= ST_OFF;
          end
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  // Status flags, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~(wr_lo && waddr_q == STATUS_OFS ? wdata_q[2:0] : 3'h0)) | {ev_stby_q, sw_set, ev_up_q};
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_q <= 2'h0;
      mode_q <= MODE_RST;
      stby_req_q <= 1'b0;
      imask_q <= IRQ_MASK_RST;
      keep_q <= STBY_KEEP_RST;
      flt_lim_q <= FLT_LIM_RST;
      wd_lim_q <= WD_LIM_RST;
    end else begin
      if (state_q == ST_OFF) begin
        tsel_q <= fused_step_period_default;
        stby_req_q <= 1'b0;
      end else if (wr_lo && waddr_q == CTRL_OFS) begin
        tsel_q <= wdata_q[1:0];
        stby_req_q <= wdata_q[CTRL_STBY_BIT];
      end
      if (wr_lo && waddr_q == CTRL_OFS) begin
        mode_q <= wdata_q[CTRL_MODE_BIT];
      end
      if (wr_lo && waddr_q == IRQ_MASK_OFS) begin
        imask_q <= wdata_q[2:0];
      end
      if (wr_lo && waddr_q == STBY_KEEP_OFS) begin
        keep_q <= wdata_q[7:0];
      end
      if (wr_lo && waddr_q == FAULT_OFS) begin
        flt_lim_q <= wdata_q[3:0];
        wd_lim_q <= wdata_q[7:4];
      end
    end
  end

  // AXI4-Lite write channel
  assign awready = !aw_got_q && !bvalid_q;
  assign wready = !w_got_q && !bvalid_q;
  assign wr_en = aw_got_q && w_got_q && !bvalid_q;
  assign wr_lo = wr_en && wstrb_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_en) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_comb begin
    case (araddr)
      CTRL_OFS: rd_val = 32'({stby_req_q, sw_off_q, mode_q, tsel_q});
      STATUS_OFS: rd_val = 32'({hard_q, 1'b0, 3'(state_q), 1'b0, flags_q});
      IRQ_MASK_OFS: rd_val = 32'(imask_q);
      STBY_KEEP_OFS: rd_val = 32'(keep_q);
      FAULT_OFS: rd_val = 32'({wd_cnt_q, flt_cnt_q, wd_lim_q, flt_lim_q});
      default: rd_val = addr_ok(araddr) ? 32'(code[4'((araddr - SLOT_BASE) >> 2)]) : 32'h0000_0000;
    endcase
  end

  assign arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign reg_enable = out_on_q[NUM_REG-1:0];
  assign power_good_pin = out_on_q[GO_IDX];
  assign host_reset_out_n = out_on_q[RST_IDX];
  assign irq_out_n = ~|(flags_q & ~imask_q);
  assign fail_safe = fail_safe_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence down_done_s;
    state_q == ST_DOWN && hard_q ##1 state_q != ST_DOWN;
  endsequence

  up_apply_a: assert property ((state_q == ST_UP && act && !hard_evt && !off_evt &&
    !(bound && slot_q > {1'b0, last_mask})) |=> ((out_on_q & $past(hit & mask_q)) == $past(hit & mask_q)))
    else $error("slot output not enabled");
  zero_off_a: assert property (state_q == ST_UP |-> (out_on_q[GO_IDX:0] & zero[GO_IDX:0]) == '0)
    else $error("zero code output enabled");
  pwrup_flag_a: assert property ($rose(state_q == ST_RUN) |=> flags_q[FLAG_PWRUP])
    else $error("power up done flag missing");
  stby_flag_a: assert property ($rose(state_q == ST_STBY) |=> flags_q[FLAG_STBY])
    else $error("standby entry flag missing");
  sw_off_a: assert property (sw_set |=> sw_off_q && flags_q[FLAG_SDWN] && sd_cnt_q == 6'h00)
    else $error("off request not started");
  cancel_a: assert property ((sw_off_q && pend_clr && on_state && !hard_evt && !off_evt) |=>
    !sw_off_q && state_q != ST_DOWN) else $error("off request not cancelled");
  hard_down_a: assert property ((on_state && fault_timer_expired) |=> state_q == ST_DOWN && hard_q)
    else $error("hard fault ignored");
  failsafe_a: assert property (down_done_s |-> state_q == ST_FAILSAFE ##1 fail_safe_q && state_q == ST_OFF)
    else $error("fail-safe skipped");
  reload_a: assert property ((state_q == ST_OFF)[*2] |-> tsel_q == $past(fused_step_period_default))
    else $error("period not reloaded");
  lock_a: assert property ((busy && $past(busy)) |-> $stable(out_on_q) || $past(act))
    else $error("enable changed off boundary");
endmodule

//--- test/board_model.sv
// Board side model driving the power-on request pin
`timescale 1ns/10ps
module board_model (
  // Clock
  input wire logic aclk,
  // Request from the bench
  input wire logic want_on,
  // Pin towards the sequencer
  output logic power_on_request_pin
);
  initial power_on_request_pin = 1'b0;
  // level on request
  // Asynchronous pin, moves a few ns after the edge
  always @(posedge aclk) begin
    power_on_request_pin <= #3 want_on;
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the power rail sequencer
`timescale 1ns/10ps
module testbench;
  import seq_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [1:0] period = 2'h0;
  logic [79:0] fuses = 0;
  logic want_on = 0, pin, wd_ev = 0, flt = 0, ftimer = 0, edge_mode = 0;
  logic [7:0] reg_enable;
  logic power_good_pin, host_reset_out_n, irq_out_n, fail_safe;
  int errors = 0, checked = 0, cyc = 0, t0, c1;

  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  power_rail_sequencer i_power_rail_sequencer (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .fused_step_period_default(period),
    .fused_slot_codes(fuses), .on_pin_edge_mode(edge_mode), .power_on_request_pin(pin),
    .reg_fault_pin(flt), .fault_timer_expired(ftimer), .watchdog_fail_event(wd_ev),
    .reg_enable(reg_enable), .power_good_pin(power_good_pin),
    .host_reset_out_n(host_reset_out_n), .irq_out_n(irq_out_n), .fail_safe(fail_safe));

  board_model i_board_model (.aclk(aclk), .want_on(want_on), .power_on_request_pin(pin));

  task automatic conclude();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= {3'($urandom), 1'b1};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 0;
    chk("write done", 1, n < 200);
  endtask

  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 200);
    r = rresp;
    d = rdata;
    rready <= 0;
    chk("read done", 1, n < 200);
  endtask

  function automatic logic probe(input int w);
    case (w)
      0: return reg_enable[0];
      1: return reg_enable[1];
      2: return host_reset_out_n;
      3: return fail_safe;
      default: return power_good_pin;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic lvl, input int lim);
    int n = 0;
    while (probe(w) !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk("wait", 1, probe(w) === lvl);
  endtask

  // Cycles from slot 0 to the slot of a given code
  function automatic int gap(input int code);
    return (code - 1) * int'(STEP0_TICKS) * TICK_CYC;
  endfunction

  function automatic bit in_gap(input int g);
    return (cyc - t0) >= g - TICK_CYC && (cyc - t0) <= g + TICK_CYC + 8;
  endfunction

  initial begin
    #1000000;
    errors++;
    conclude();
  end

  initial begin
    c1 = 2 + $urandom(32'h9915) % 2;
    c1 = 2 + $urandom % 2;
    fuses = {8'h00, 8'h02, 48'h0, 8'(c1), 8'h01};
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    chk("enables", 0, reg_enable);
    chk("host reset", 0, host_reset_out_n);
    chk("irq idle", 1, irq_out_n);
    rd(IRQ_MASK_OFS);
    chk("mask", 32'(IRQ_MASK_RST), d);
    rd(FAULT_OFS);
    chk("limits", {WD_LIM_RST, FLT_LIM_RST}, d[7:0]);
    rd(8'h4C);
    chk("unmapped", RESP_SLVERR, r);
    wr(8'h4C, 32'h0000_0000);
    chk("bad write", RESP_SLVERR, r);
    want_on <= 1;
    wait_for(0, 1, 20000);
    t0 = cyc;
    wait_for(4, 1, 20000);
    chk("go slot", 1, in_gap(gap(2)));
    wait_for(1, 1, 20000);
    chk("reg1 slot", 1, in_gap(gap(c1)));
    chk("unused off", 8'h03, reg_enable);
    wait_for(2, 1, 20000);
    chk("reset last", 8'h03, reg_enable);
    rd(STATUS_OFS);
    chk("up done", 32'h21, d & 32'h77);
    wr(SLOT_BASE + 8'h08, 32'h01);
    rd(SLOT_BASE + 8'h08);
    chk("slot write", 32'h01, d);
    wr(STATUS_OFS, 32'h01);
    chk("irq clear", 1, irq_out_n);
    wr(CTRL_OFS, 32'h08);
    rd(STATUS_OFS);
    chk("pending", 1, d[FLAG_SDWN]);
    chk("irq set", 0, irq_out_n);
    wr(STATUS_OFS, 32'h02);
    rd(CTRL_OFS);
    chk("off cleared", 0, d[CTRL_OFF_BIT]);
    rd(STATUS_OFS);
    chk("still run", 2, d[6:4]);
    wr(CTRL_OFS, 32'h08);
    wait_for(1, 0, 60000);
    chk("down order", 1, reg_enable[0]);
    t0 = cyc;
    wait_for(0, 0, 20000);
    chk("down gap", 1, cyc - t0 >= gap(2) - TICK_CYC);
    wait_for(2, 1, 40000);
    chk("reload", 8'h03, reg_enable);
    rd(SLOT_BASE + 8'h08);
    chk("slot reload", 0, d);
    wr(FAULT_OFS, 32'h20);
    wr(CTRL_OFS, 32'h04);
    chk("bresp", RESP_OKAY, r);
    repeat (2) begin
      @(posedge aclk);
      wd_ev <= 1;
      @(posedge aclk);
      wd_ev <= 0;
    end
    wait_for(1, 0, 5000);
    chk("grouped", 0, reg_enable[0]);
    wait_for(3, 1, 30000);
    chk("fail-safe off", 0, reg_enable);
    wr(FAULT_OFS, 32'h02);
    repeat (2) begin
      @(posedge aclk);
      flt <= 1;
      @(posedge aclk);
      flt <= 0;
    end
    wait_for(3, 1, 5000);
    @(posedge aclk);
    ftimer <= 1;
    fuses <= '0;
    @(posedge aclk);
    ftimer <= 0;
    wait_for(3, 1, 5000);
    wait_for(2, 1, 8);
    chk("slave off", 0, {power_good_pin, reg_enable});
    wr(STATUS_OFS, 32'h07);
    wr(CTRL_OFS, 32'h11);
    rd(STATUS_OFS);
    chk("stby bypass", 32'h44, d & 32'h77);
    rd(CTRL_OFS);
    chk("period rewrite", 1, d[1:0]);
    wr(CTRL_OFS, 32'h00);
    rd(STATUS_OFS);
    chk("run bypass", 32'h25, d & 32'h77);
    conclude();
  end
endmodule
